// file: logic/sarc_map.vh
// Register map, field positions, reset values and timing for the converter control.
// Assumes a plain byte-wide register port and a 50 MHz system clock.
`ifndef SARC_MAP_VH
`define SARC_MAP_VH
`define SARC_ADDR_W 3
`define SARC_OFF_CTRL 3'h0
`define SARC_OFF_CFG 3'h1
`define SARC_OFF_IEN 3'h2
`define SARC_OFF_FLG 3'h3
`define SARC_OFF_RESH 3'h4
`define SARC_OFF_RESL 3'h5
`define SARC_OFF_SLP 3'h6
`define SARC_RST_CTRL 8'h00
`define SARC_RST_CFG 8'h0F
`define SARC_RST_IEN 8'h00
`define SARC_RST_FLG 8'h00
`define SARC_CTRL_MASK 8'hDF
`define SARC_CFG_MASK 8'h7F
`define SARC_IRQ_MASK 8'h40
`define SARC_B_ON 0
`define SARC_B_GO 1
`define SARC_CH_LO 2
`define SARC_CH_HI 4
`define SARC_B_REF 6
`define SARC_B_FMT 7
`define SARC_CS_LO 4
`define SARC_CS_HI 6
`define SARC_B_DONE 6
`define SARC_B_GIE 1
`define SARC_B_SLEEP 0
`define SARC_NBITS 4'hB
`define SARC_ABORT_BP 4'h2
`define SARC_RC_DIV 8'hC8
`define SARC_CS_RC 2'h3
`endif

// file: logic/sarc_bit_clock.v
// Bit-period tick generator for the converter.
// Assumes sys_clk; the RC source is modelled as a fixed slow divide of sys_clk.
`default_nettype none
`include "sarc_map.vh"
module sarc_bit_clock (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Select and tick.
  input wire [2:0] convClockSelect,
  output reg bitTick_r
);
  reg [7:0] cnt_r;
  reg [2:0] selPrev_r;
  reg [7:0] limit;
  always @* begin
    // Codes 000..110 pick divide 2..64; x11 is the internal RC source.
    if (convClockSelect[1:0] == `SARC_CS_RC) begin
      limit = `SARC_RC_DIV;
    end else begin
      limit = 8'h02 << {convClockSelect[1:0], convClockSelect[2]};
    end
  end
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      selPrev_r <= 3'h0;
      bitTick_r <= 1'b0;
    end else begin
      selPrev_r <= convClockSelect;
      if (selPrev_r != convClockSelect || cnt_r == limit - 8'h01) begin
        cnt_r <= 8'h00;
        bitTick_r <= (selPrev_r == convClockSelect);
      end else begin
        cnt_r <= cnt_r + 8'h01;
        bitTick_r <= 1'b0;
      end
    end
  end
endmodule // sarc_bit_clock
`default_nettype wire

// file: logic/sarc_control.v
// Control for a 10-bit successive-approximation converter.
// Assumes an analog comparator outside that answers compHigh each bit period.
// Notes on behaviour
// - Ten-bit result built one bit per bit period by successive approximation.
// - Result registers are read-only; writes to them do nothing.
// - Channel select routes exactly one input to the sample-and-hold.
// - Reference bit picks supply or external pin; negative reference is ground.
// - Three-bit clock select picks divide 2 to 64 or the RC source.
// - A conversion takes eleven bit periods.
// - Non-RC clocks derive from the system clock.
// - Done flag sets at every completion regardless of interrupt enable.
// - Enabled set flag raises interrupt, running or asleep, and wakes.
// - After wake, next instruction runs; vector only if global enable set.
// - Format bit selects left or right justification.
// - Enable bit powers converter; status bit starts a conversion.
// - Completion clears status, sets flag, updates results together.
// - Aborted conversion keeps old result; acquisition restarts after two periods.
// - Left format: high holds bits 9..2, low top bits hold 1..0.
//
// The plain strobed port and the register offsets are this design's own decisions.
`default_nettype none
`include "sarc_map.vh"
module sarc_control (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register port.
  input wire [`SARC_ADDR_W-1:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata_r,
  // Analog side.
  input wire compHigh,
  output reg [2:0] channelSelect_r,
  output reg referenceSelect_r,
  output reg converterPower_r,
  output reg sampleHold_r,
  output reg [9:0] dacCode_r,
  output reg [3:0] pinAnalogSelect_r,
  // Processor side.
  output reg irqReq_r,
  output reg wakeReq_r,
  output reg vectorReq_r
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CONV = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_ACQ = 4'h8;

  reg [7:0] ctrl_r;
  reg [7:0] cfg_r;
  reg [7:0] ien_r;
  reg [7:0] flg_r;
  reg [1:0] sys_r;
  reg [9:0] result_r;
  reg [9:0] sar_r;
  reg [3:0] bitCnt_r;
  reg [3:0] state_r;
  reg [2:0] nextCh_r;
  reg cmpMeta_r;
  reg cmpSync_r;
  reg asleepPrev_r;
  wire bitTick;
  wire done;
  wire abort;
  wire ctrlWr;
  wire flgWr;
  wire [7:0] resHigh;
  wire [7:0] resLow;

  sarc_bit_clock u_bit_clock (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .convClockSelect(cfg_r[`SARC_CS_HI:`SARC_CS_LO]),
    .bitTick_r(bitTick)
  );

  assign ctrlWr = regWr && (regAddr == `SARC_OFF_CTRL);
  assign flgWr = regWr && (regAddr == `SARC_OFF_FLG);
  // Completion at the eleventh period: one for sample, ten for the bits.
  assign done = (state_r == ST_CONV) && bitTick && (bitCnt_r == `SARC_NBITS - 4'h1);
  assign abort = ctrlWr && !regWdata[`SARC_B_GO] && ctrl_r[`SARC_B_GO];

  // Result layouts for the two formats.
  assign resHigh = ctrl_r[`SARC_B_FMT] ? {6'h00, result_r[9:8]} : result_r[9:2];
  assign resLow = ctrl_r[`SARC_B_FMT] ? result_r[7:0] : {result_r[1:0], 6'h00};

  // Comparator output is analog-timed, so synchronise it.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cmpMeta_r <= 1'b0;
      cmpSync_r <= 1'b0;
    end else begin
      cmpMeta_r <= compHigh;
      cmpSync_r <= cmpMeta_r;
    end
  end

  // Control register: hardware clears the status bit at completion.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= `SARC_RST_CTRL;
    end else if (ctrlWr) begin
      ctrl_r <= regWdata & `SARC_CTRL_MASK;
      if (!regWdata[`SARC_B_ON]) begin
        ctrl_r[`SARC_B_GO] <= 1'b0;
      end
    end else if (done) begin
      ctrl_r[`SARC_B_GO] <= 1'b0;
    end
  end

  // Configuration, interrupt enable and processor state registers.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_r <= `SARC_RST_CFG;
      ien_r <= `SARC_RST_IEN;
      sys_r <= 2'h0;
    end else if (regWr) begin
      if (regAddr == `SARC_OFF_CFG) begin
        cfg_r <= regWdata & `SARC_CFG_MASK;
      end
      if (regAddr == `SARC_OFF_IEN) begin
        ien_r <= regWdata & `SARC_IRQ_MASK;
      end
      if (regAddr == `SARC_OFF_SLP) begin
        sys_r <= regWdata[1:0];
      end
    end
  end

  // Done flag: a completion in the same cycle as a clear still sets it.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      flg_r <= `SARC_RST_FLG;
    end else if (done) begin
      flg_r[`SARC_B_DONE] <= 1'b1;
    end else if (flgWr) begin
      flg_r <= regWdata & `SARC_IRQ_MASK;
    end
  end

  // Conversion sequencer.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      sar_r <= 10'h000;
      result_r <= 10'h000;
      nextCh_r <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          bitCnt_r <= 4'h0;
          if (ctrl_r[`SARC_B_GO] && ctrl_r[`SARC_B_ON]) begin
            state_r <= ST_CONV;
            sar_r <= 10'h200;
          end
        end
        ST_CONV: begin
          if (abort || !ctrl_r[`SARC_B_ON]) begin
            state_r <= ST_HOLD;
            bitCnt_r <= 4'h0;
          end else if (bitTick) begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r != 4'h0) begin
              // Keep the trial bit if the input is above it, then try the next.
              if (!cmpSync_r) begin
                // Drop the previous trial bit, which sits one place above the new one.
                sar_r <= (sar_r & ~(10'h200 >> (bitCnt_r - 4'h1))) | (10'h200 >> bitCnt_r);
              end else begin
                sar_r <= sar_r | (10'h200 >> bitCnt_r);
              end
            end
            if (done) begin
              result_r <= cmpSync_r ? sar_r : (sar_r & 10'h3FE);
              state_r <= ST_IDLE;
            end
          end
        end
        ST_HOLD: begin
          if (bitTick) begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == `SARC_ABORT_BP - 4'h1) begin
              state_r <= ST_ACQ;
            end
          end
        end
        ST_ACQ: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      if (state_r == ST_IDLE) begin
        nextCh_r <= ctrl_r[`SARC_CH_HI:`SARC_CH_LO];
      end
    end
  end

  // Analog controls, interrupt and wake outputs.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      channelSelect_r <= 3'h0;
      referenceSelect_r <= 1'b0;
      converterPower_r <= 1'b0;
      sampleHold_r <= 1'b0;
      dacCode_r <= 10'h000;
      pinAnalogSelect_r <= 4'hF;
      irqReq_r <= 1'b0;
      wakeReq_r <= 1'b0;
      vectorReq_r <= 1'b0;
      asleepPrev_r <= 1'b0;
    end else begin
      channelSelect_r <= (state_r == ST_IDLE) ? ctrl_r[`SARC_CH_HI:`SARC_CH_LO] : nextCh_r;
      referenceSelect_r <= ctrl_r[`SARC_B_REF];
      converterPower_r <= ctrl_r[`SARC_B_ON];
      sampleHold_r <= (state_r != ST_CONV) && (state_r != ST_HOLD);
      dacCode_r <= sar_r;
      pinAnalogSelect_r <= cfg_r[3:0];
      irqReq_r <= ien_r[`SARC_B_DONE] && flg_r[`SARC_B_DONE];
      asleepPrev_r <= sys_r[`SARC_B_SLEEP];
      wakeReq_r <= sys_r[`SARC_B_SLEEP] && ien_r[`SARC_B_DONE] && flg_r[`SARC_B_DONE];
      // Vector only after the post-wake instruction, and only with global enable.
      vectorReq_r <= ien_r[`SARC_B_DONE] && flg_r[`SARC_B_DONE] && sys_r[`SARC_B_GIE]
        && !sys_r[`SARC_B_SLEEP] && !asleepPrev_r;
    end
  end

  // Read port; unmapped addresses and unused bits read zero.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata_r <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `SARC_OFF_CTRL: regRdata_r <= ctrl_r;
        `SARC_OFF_CFG: regRdata_r <= cfg_r;
        `SARC_OFF_IEN: regRdata_r <= ien_r;
        `SARC_OFF_FLG: regRdata_r <= flg_r;
        `SARC_OFF_RESH: regRdata_r <= resHigh;
        `SARC_OFF_RESL: regRdata_r <= resLow;
        `SARC_OFF_SLP: regRdata_r <= {6'h00, sys_r};
        default: regRdata_r <= 8'h00;
      endcase
    end else begin
      regRdata_r <= 8'h00;
    end
  end
endmodule // sarc_control
`default_nettype wire

// file: sim/sarc_control_monitor.sv
// Port checker for the converter control.
// Assumes it is bound to sarc_control and sees only its ports.
`default_nettype none
`include "sarc_map.vh"
module sarc_control_monitor (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [`SARC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata_r,
  // Converter and processor side.
  input wire logic [2:0] channelSelect_r,
  input wire logic referenceSelect_r,
  input wire logic converterPower_r,
  input wire logic sampleHold_r,
  input wire logic [3:0] pinAnalogSelect_r,
  input wire logic irqReq_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wrCtl;
  assign wrCtl = regWr && regAddr == `SARC_OFF_CTRL;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Register then output flop: a write shows on the pins two cycles later.
  reset_values_a: assert property (disable iff (1'b0) !rst_n |=>
    regRdata_r == 8'h00 && !irqReq_r && pinAnalogSelect_r == 4'hF) else $error("reset values");
  read_idle_a: assert property (!regRd |=> regRdata_r == 8'h00)
    else $error("read data outside read");
  read_unmapped_a: assert property (regRd && regAddr == 3'h7 |=> regRdata_r == 8'h00)
    else $error("unmapped read not zero");
  power_bit_a: assert property (wrCtl |=> ##1 converterPower_r == $past(regWdata[0], 2))
    else $error("power bit not applied");
  channel_route_a: assert property (wrCtl |=> ##1 channelSelect_r == $past(regWdata[4:2], 2))
    else $error("channel not applied");
  reference_bit_a: assert property (wrCtl |=> ##1 referenceSelect_r == $past(regWdata[6], 2))
    else $error("reference not applied");
  analog_sel_a: assert property (regWr && regAddr == `SARC_OFF_CFG |=> ##1
    pinAnalogSelect_r == $past(regWdata[3:0], 2)) else $error("analog select not applied");
  hold_on_go_a: assert property (wrCtl && regWdata[1:0] == 2'h3 && converterPower_r
    |-> ##[1:6] !sampleHold_r) else $error("no hold after start");
  cover property (wrCtl && regWdata[1]);
  cover property ($rose(irqReq_r));
  cover property (regRd && regAddr == 3'h7);
endmodule // sarc_control_monitor
bind sarc_control sarc_control_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata_r(regRdata_r), .channelSelect_r(channelSelect_r),
  .referenceSelect_r(referenceSelect_r), .converterPower_r(converterPower_r),
  .sampleHold_r(sampleHold_r), .pinAnalogSelect_r(pinAnalogSelect_r), .irqReq_r(irqReq_r));
`default_nettype wire

// file: sim/sarc_analog_model.sv
// Far-side model: analog inputs and comparator; no sample-and-hold is modelled.
// Assumes channel n carries the fixed code {n, 7'h4D}, known to the bench.
`default_nettype none
module sarc_analog_model (
  // Clock.
  input wire logic sys_clk,
  // Converter side.
  input wire logic [2:0] channelSelect_r,
  input wire logic converterPower_r,
  input wire logic [9:0] dacCode_r,
  output var logic compHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] level;
  assign level = {channelSelect_r, 7'h4D};
  initial compHigh = 1'b0;
  // An unpowered comparator gives no valid answer, so it toggles instead of holding.
  always @(posedge sys_clk) begin
    compHigh <= converterPower_r ? (level >= dacCode_r) : ~compHigh;
  end
endmodule // sarc_analog_model
`default_nettype wire

// file: sim/sarc_control_tb.sv
// Self-checking bench for the converter control.
// Assumes the analog model answers the comparator input.
`default_nettype none
`include "sarc_map.vh"
module sarc_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sysClk, rstN, regWr, regRd, compHigh, refSel, pwr, sh, irq, wake, vect;
  logic [2:0] regAddr, chSel;
  logic [7:0] regWdata, regRdata, rv, hiE, loE;
  logic [9:0] dac;
  logic [3:0] pinSel;
  int failCount, checkCount, cyc;
  sarc_control DUT (.sys_clk(sysClk), .rst_n(rstN), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata), .compHigh(compHigh),
    .channelSelect_r(chSel), .referenceSelect_r(refSel), .converterPower_r(pwr),
    .sampleHold_r(sh), .dacCode_r(dac), .pinAnalogSelect_r(pinSel), .irqReq_r(irq),
    .wakeReq_r(wake), .vectorReq_r(vect));
  sarc_analog_model MDL (.sys_clk(sysClk), .channelSelect_r(chSel), .converterPower_r(pwr),
    .dacCode_r(dac), .compHigh(compHigh));
  task automatic printVerdict;
    $display("checks %0d errors %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      failCount++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sysClk);
    regWr <= 1'b0;
  endtask
  task automatic rdv(input logic [2:0] a);
    @(posedge sysClk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sysClk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    rdv(a);
    chk(rv, exp);
  endtask
  // Power first, start later: starting in the same write as power-up is not allowed.
  task automatic runConv(input logic [7:0] ctl);
    time t0;
    wr(`SARC_OFF_CTRL, ctl);
    repeat (4) @(posedge sysClk);
    wr(`SARC_OFF_CTRL, ctl | 8'h03);
    t0 = $time;
    cyc = 0;
    do begin
      rdv(`SARC_OFF_CTRL);
      cyc++;
    end while (rv[1] && cyc < 3000);
    if (rv[1]) begin
      $display("[ERR] %0t conversion never completed", $time);
      failCount++;
      printVerdict();
    end
    chk(rv, ctl);
    cyc = int'(($time - t0) / 20);
  endtask
  function automatic int dv(input logic [2:0] cs);
    return cs[1:0] == 2'h3 ? 200 : 2 << {cs[1:0], cs[2]};
  endfunction
  task automatic tReset;
    rdc(`SARC_OFF_CTRL, 8'h00);
    rdc(`SARC_OFF_CFG, 8'h0F);
    rdc(`SARC_OFF_IEN, 8'h00);
    rdc(`SARC_OFF_FLG, 8'h00);
    rdc(3'h7, 8'h00);
    chk({4'h0, pinSel}, 8'h0F);
  endtask
  task automatic tClocks;
    logic [9:0] lv;
    for (int i = 0; i < 8; i++) begin
      lv = {1'b0, i[1:0], 7'h4D};
      hiE = i[0] ? {6'h00, lv[9:8]} : lv[9:2];
      loE = i[0] ? lv[7:0] : {lv[1:0], 6'h00};
      wr(`SARC_OFF_CFG, {1'b0, i[2:0], 4'hF});
      wr(`SARC_OFF_SLP, {7'h00, i[1] & i[0]});
      runConv({i[0], i[1], 2'h0, i[1:0], 2'h1});
      chk({7'h0, cyc >= 10 * dv(i[2:0]) && cyc <= 12 * dv(i[2:0]) + 8}, 8'h01);
      chk({7'h0, refSel}, {7'h0, i[1]});
      chk({5'h0, chSel}, {6'h0, i[1:0]});
      rdc(`SARC_OFF_FLG, 8'h40);
      chk({7'h0, irq}, 8'h00);
      // Divides 2 and 4 are shorter than the comparator path, so no valid result is due.
      if (dv(i[2:0]) >= 8) begin
        rdc(`SARC_OFF_RESH, hiE);
        rdc(`SARC_OFF_RESL, loE);
      end
      wr(`SARC_OFF_FLG, 8'h00);
    end
  endtask
  task automatic tReadOnly;
    wr(`SARC_OFF_RESH, 8'hFF);
    wr(`SARC_OFF_RESL, 8'h00);
    rdc(`SARC_OFF_RESH, hiE);
    rdc(`SARC_OFF_RESL, loE);
  endtask
  task automatic tAbort;
    wr(`SARC_OFF_CTRL, 8'h81);
    wr(`SARC_OFF_CTRL, 8'h83);
    repeat (6) @(posedge sysClk);
    wr(`SARC_OFF_CTRL, 8'h81);
    rdc(`SARC_OFF_CTRL, 8'h81);
    repeat (600) @(posedge sysClk);
    rdc(`SARC_OFF_FLG, 8'h00);
    rdc(`SARC_OFF_RESH, hiE);
    rdc(`SARC_OFF_RESL, loE);
  endtask
  task automatic tIrq;
    wr(`SARC_OFF_IEN, 8'h40);
    wr(`SARC_OFF_CFG, 8'h0F);
    for (int g = 0; g < 2; g++) begin
      wr(`SARC_OFF_SLP, {6'h00, g[0], 1'b1});
      runConv(8'h05);
      repeat (4) @(posedge sysClk);
      // Asleep: request and wake, but no vector before the next instruction has run.
      chk({5'h0, irq, wake, vect}, 8'h06);
      wr(`SARC_OFF_SLP, {6'h00, g[0], 1'b0});
      repeat (3) @(posedge sysClk);
      chk({5'h0, irq, wake, vect}, {6'h01, 1'b0, g[0]});
      wr(`SARC_OFF_FLG, 8'h00);
      repeat (2) @(posedge sysClk);
      chk({7'h0, irq}, 8'h00);
    end
  endtask
  initial begin
    sysClk = 1'b0;
    forever #10 sysClk = ~sysClk;
  end
  initial begin
    rstN = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    failCount = 0;
    checkCount = 0;
    repeat (8) @(posedge sysClk);
    rstN <= 1'b1;
    tReset();
    tClocks();
    tReadOnly();
    tAbort();
    tIrq();
    printVerdict();
  end
endmodule // sarc_control_tb
`default_nettype wire
